/* File: design/pse_port_shutdown_control.sv */
// Pin-level control of an eight-port power sourcing controller: interrupt and
// serial data pins, filtered fast shutdown with pulse codes, filtered reset,
// and the per-port sequence from backoff through detection to power.
// Assumes analog comparators and the serial engine sit outside, synchronous.
//
// Behaviour
// [RULE1] The interrupt pin is pulled low while any interrupt flag is set and released otherwise.
// [RULE2] The fast shutdown pin is active high, idles low and ignores pulses shorter than the deglitch window.
// [RULE3] A port shut down through the fast shutdown pin goes through the same turn-off as a reset command.
// [RULE4] Pulses on the shutdown pin form a three-bit code that turns off the ports at up to eight priority levels.
// [RULE5] A filtered low on the reset pin turns every port off and returns all state to power-up values; shutdown_code, sd_shift and pin outputs keep theirs.
// [RULE6] A power-on reset acts on its own, independent of the reset pin.
// [RULE7] A port found above the voltage threshold gets the discharge resistor and a backoff before detection.
// [RULE8] Detection sinks two distinct probe currents while the port voltage is judged four-point.
// [RULE9] The gate drive is forced low on a low supply, an overcurrent timeout or a manual shutdown.
// [RULE10] A fast overload turns the transistor off well within one microsecond.
// [RULE11] The sense resistor to the high-voltage supply is on except during detection or while powered.
// [RULE12] The bus address comes from four address pins that read one when left open.
// [RULE13] Serial data uses a separate input and an open-drain output, which may be tied together.
// [RULE14] Classification may run on several ports at once.
// [RULE15] Shutdown pulse timing and bit order are module parameters.
`include "pse_map.svh"

module pse_port_shutdown_control
  import pse_pkg::*;
#(
  parameter int PORTS = `PSE_PORTS,
  parameter int DEGLITCH_CYC = `PSE_DEGLITCH_CYC,
  parameter int BACKOFF_CYC = `PSE_BACKOFF_CYC,
  parameter int PROBE_CYC = `PSE_PROBE_CYC,
  parameter int SD_LONG_CYC = `PSE_SD_LONG_CYC,
  parameter int SD_GAP_CYC = `PSE_SD_GAP_CYC,
  parameter bit SD_MSB_FIRST = 1'b1
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Control pins
  input wire logic reset_in_n,
  input wire logic fast_shutdown_in,
  // Interrupt pin, open drain
  input wire logic [7:0] int_flags,
  output logic int_out,
  output logic int_oe,
  // Serial bus pins and the engine behind them
  input wire logic serial_data_in,
  input wire logic sda_drive_low,
  input wire logic [3:0] bus_address_pins,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic serial_data_rx,
  output logic [3:0] bus_address,
  // Per-port status from the analog side
  input wire logic supply_ok,
  input wire logic [PORTS-1:0] port_enable,
  input wire logic [PORTS-1:0] port_volt_high,
  input wire logic [PORTS-1:0] detect_valid,
  input wire logic [PORTS-1:0] class_done,
  input wire logic [PORTS-1:0] oc_timeout,
  input wire logic [PORTS-1:0] fast_overload,
  input wire logic [PORTS-1:0] manual_shutdown,
  input wire logic [PORTS*`PSE_CODE_BITS-1:0] port_priority,
  // Per-port drive
  output logic [PORTS-1:0] port_gate_drive,
  output logic [PORTS-1:0] discharge_en,
  output logic [PORTS-1:0] probe_low_en,
  output logic [PORTS-1:0] probe_high_en,
  output logic [PORTS-1:0] class_en,
  output logic [PORTS-1:0] sense_res_en,
  // Shutdown code seen
  output logic [`PSE_CODE_BITS-1:0] shutdown_code,
  output logic shutdown_event
);
  localparam int CB = `PSE_CODE_BITS;
  localparam int TW = $clog2(BACKOFF_CYC + PROBE_CYC + 1);
  localparam int PW = $clog2(SD_GAP_CYC + SD_LONG_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin filters

  deglitch_if sd_pin ();
  deglitch_if rst_pin ();
  assign sd_pin.raw = fast_shutdown_in;
  assign rst_pin.raw = reset_in_n;

  // Shutdown pin idles low as its pull-down would hold it
  pin_deglitch #(.WINDOW_CYC(DEGLITCH_CYC), .INIT(1'b0)) u_sd_filter ( // see [RULE2]
    .clk(clk),
    .arst_n(arst_n),
    .pin(sd_pin.filt)
  );

  // Reset pin idles high as its pull-up would hold it
  pin_deglitch #(.WINDOW_CYC(DEGLITCH_CYC), .INIT(1'b1)) u_rst_filter ( // see [RULE5]
    .clk(clk),
    .arst_n(arst_n),
    .pin(rst_pin.filt)
  );

  // The pin reset is synchronous; arst_n alone is the power-on reset
  wire soft_reset = !rst_pin.clean; // see [RULE5] [RULE6]

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and serial pins

  // Open drain: data is always low, the enable does the signalling
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_out <= 1'b0;
      int_oe <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_out_oe <= 1'b0;
      serial_data_rx <= 1'b1;
      bus_address <= 4'hf;
    end else begin
      int_out <= 1'b0;
      int_oe <= |int_flags; // see [RULE1]
      serial_data_out <= 1'b0;
      serial_data_out_oe <= sda_drive_low; // see [RULE13]
      serial_data_rx <= serial_data_in; // see [RULE13]
      bus_address <= bus_address_pins; // see [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown pulse code decoder

  logic sd_prev;
  logic [PW-1:0] sd_len;
  logic [1:0] sd_nbits;
  logic [CB-1:0] sd_shift;
  logic [PORTS-1:0] sd_hit;

  wire sd_rise = sd_pin.clean && !sd_prev;
  wire sd_fall = !sd_pin.clean && sd_prev;
  wire sd_bit = sd_len >= PW'(SD_LONG_CYC);
  // Bit order is a build choice since the host firmware fixes it
  wire [CB-1:0] sd_next_shift = SD_MSB_FIRST ? {sd_shift[CB-2:0], sd_bit} : {sd_bit, sd_shift[CB-1:1]}; // see [RULE15]
  wire sd_done = sd_fall && (sd_nbits == 2'(CB - 1));
  wire sd_gap_out = !sd_pin.clean && (sd_nbits != 2'd0) && (sd_len >= PW'(SD_GAP_CYC));
  wire sd_len_max = sd_len == {PW{1'b1}};

  // Length counter measures the high pulse, then the low gap after it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sd_prev <= 1'b0;
      sd_len <= '0;
    end else begin
      sd_prev <= sd_pin.clean;
      sd_len <= (sd_rise || sd_fall || soft_reset) ? '0 : (sd_len_max ? sd_len : sd_len + PW'(1));
    end
  end

  // Three bits complete a code; a long gap discards a partial one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sd_nbits <= 2'd0;
      sd_shift <= '0;
      shutdown_code <= '0;
      shutdown_event <= 1'b0;
    end else begin
      shutdown_event <= sd_done && !soft_reset; // see [RULE4]
      if (soft_reset || sd_gap_out || sd_done) begin
        sd_nbits <= 2'd0;
      end else if (sd_fall) begin
        sd_nbits <= sd_nbits + 2'd1;
      end
      if (sd_fall) begin
        sd_shift <= sd_next_shift;
      end
      if (sd_done && !soft_reset) begin
        shutdown_code <= sd_next_shift; // see [RULE4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port sequencer

  for (genvar i = 0; i < PORTS; i++) begin : g_port
    port_state_t state;
    port_state_t next_state;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    // A port at or below the code in importance (higher number) is dropped
    assign sd_hit[i] = sd_done && (port_priority[i*CB +: CB] >= sd_next_shift); // see [RULE4]
    // Every turn-off cause funnels into the reset-command path
    wire kill = soft_reset || sd_hit[i] || !port_enable[i] || !supply_ok || oc_timeout[i] // see [RULE3] [RULE9]
      || fast_overload[i] || manual_shutdown[i]; // see [RULE10]
    wire timer_zero = timer == '0;

    always_comb begin
      next_state = state;
      next_timer = timer_zero ? timer : timer - TW'(1);
      unique case (state)
        ST_IDLE: begin
          if (port_volt_high[i]) begin
            next_state = ST_BACKOFF; // see [RULE7]
            next_timer = TW'(BACKOFF_CYC - 1);
          end else begin
            next_state = ST_DET_LO;
            next_timer = TW'(PROBE_CYC - 1);
          end
        end
        ST_BACKOFF: begin
          if (timer_zero) begin
            next_state = ST_DET_LO;
            next_timer = TW'(PROBE_CYC - 1);
          end
        end
        ST_DET_LO: begin
          if (timer_zero) begin
            next_state = ST_DET_HI; // see [RULE8]
            next_timer = TW'(PROBE_CYC - 1);
          end
        end
        ST_DET_HI: begin
          if (timer_zero) begin
            next_state = detect_valid[i] ? ST_CLASS : ST_IDLE; // see [RULE8]
          end
        end
        ST_CLASS: begin
          if (class_done[i]) begin
            next_state = ST_ON; // see [RULE14]
          end
        end
        ST_ON: next_state = ST_ON;
        default: next_state = ST_IDLE;
      endcase
      if (kill) begin
        next_state = ST_IDLE;
        next_timer = '0;
      end
    end

    // Outputs are decoded from the next state so they settle with it
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        state <= ST_IDLE;
        timer <= '0;
        port_gate_drive[i] <= 1'b0;
        discharge_en[i] <= 1'b0;
        probe_low_en[i] <= 1'b0;
        probe_high_en[i] <= 1'b0;
        class_en[i] <= 1'b0;
        sense_res_en[i] <= 1'b1;
      end else begin
        state <= next_state;
        timer <= next_timer;
        port_gate_drive[i] <= next_state == ST_ON; // see [RULE9] [RULE10]
        discharge_en[i] <= next_state == ST_BACKOFF; // see [RULE7]
        probe_low_en[i] <= next_state == ST_DET_LO; // see [RULE8]
        probe_high_en[i] <= next_state == ST_DET_HI; // see [RULE8]
        // No arbitration: each port classifies on its own
        class_en[i] <= next_state == ST_CLASS; // see [RULE14]
        sense_res_en[i] <= !(next_state inside {ST_DET_LO, ST_DET_HI, ST_ON}); // see [RULE11]
      end
    end
  end
endmodule

/* File: design/pse_map.svh */
// Constants for the port shutdown and control logic: timing figures and counts.
// Assumes a single 100 MHz clock; included by bare name wherever needed.
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH

`define PSE_PORTS 8
`define PSE_CODE_BITS 3
`define PSE_CLK_PERIOD_NS 10
// Deglitch window on the shutdown and reset pins (lower bound of 1 us to 5 us)
`define PSE_DEGLITCH_NS 1000
`define PSE_DEGLITCH_CYC ((`PSE_DEGLITCH_NS + `PSE_CLK_PERIOD_NS - 1) / `PSE_CLK_PERIOD_NS)
// Detect backoff after a charged port is found
`define PSE_BACKOFF_MS 400
`define PSE_BACKOFF_CYC (`PSE_BACKOFF_MS * 1000000 / `PSE_CLK_PERIOD_NS)
// Duration of each of the two probe current phases
`define PSE_PROBE_US 20
`define PSE_PROBE_CYC ((`PSE_PROBE_US * 1000 + `PSE_CLK_PERIOD_NS - 1) / `PSE_CLK_PERIOD_NS)
// Shutdown pulse code: a pulse longer than this is a one
`define PSE_SD_LONG_US 20
`define PSE_SD_LONG_CYC ((`PSE_SD_LONG_US * 1000 + `PSE_CLK_PERIOD_NS - 1) / `PSE_CLK_PERIOD_NS)
// Shutdown pulse code: a low gap this long abandons an unfinished code
`define PSE_SD_GAP_US 100
`define PSE_SD_GAP_CYC (`PSE_SD_GAP_US * 1000 / `PSE_CLK_PERIOD_NS)

`endif

/* File: design/pse_pkg.sv */
// Types shared by the port shutdown and control logic.
// Assumes nothing beyond the map header for its figures.
package pse_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_BACKOFF = 3'b001,
    ST_DET_LO  = 3'b010,
    ST_DET_HI  = 3'b011,
    ST_CLASS   = 3'b100,
    ST_ON      = 3'b101
  } port_state_t;
endpackage

/* File: design/deglitch_if.sv */
// Carrier between a pin filter and the logic that uses its cleaned level.
// Assumes the raw level is already synchronous to the filter clock.
interface deglitch_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

/* File: design/pin_deglitch.sv */
// Level filter for a slow control pin: output follows the pin only after it
// has held a new level for a whole window. Assumes a synchronous input.
module pin_deglitch #(
  parameter int WINDOW_CYC = 100,
  parameter bit INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pin level in, filtered level out
  deglitch_if.filt pin
);
  localparam int CW = $clog2(WINDOW_CYC + 1);
  logic [CW-1:0] cnt;
  wire differs = pin.raw != pin.clean;
  wire expired = cnt == CW'(WINDOW_CYC - 1);

  // Any return to the old level restarts the window, so short pulses vanish
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      pin.clean <= INIT;
    end else if (!differs) begin
      cnt <= '0;
    end else if (expired) begin
      cnt <= '0;
      pin.clean <= pin.raw;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule

/* File: dv/pse_port_shutdown_control_props.sv */
// Checker for the port shutdown and control block: pin relations and port kills.
// Assumes it is bound to the top module and sees only that module's ports.
module pse_port_shutdown_control_props #(
  parameter int PORTS = 8,
  parameter int DEGLITCH_CYC = 100
) (
  // Clock, resets and control pins
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_in_n,
  // Interrupt and serial pins
  input wire logic [7:0] int_flags,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic sda_drive_low,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic [3:0] bus_address_pins,
  input wire logic [3:0] bus_address,
  // Port faults and priorities
  input wire logic supply_ok,
  input wire logic [PORTS-1:0] oc_timeout,
  input wire logic [PORTS-1:0] fast_overload,
  input wire logic [PORTS-1:0] manual_shutdown,
  input wire logic [PORTS*3-1:0] port_priority,
  // Port drive and shutdown code
  input wire logic [PORTS-1:0] port_gate_drive,
  input wire logic [PORTS-1:0] probe_low_en,
  input wire logic [PORTS-1:0] probe_high_en,
  input wire logic [PORTS-1:0] sense_res_en,
  input wire logic [2:0] shutdown_code,
  input wire logic shutdown_event
);
  logic [PORTS-1:0] fault;
  logic [PORTS-1:0] hit;
  logic [7:0] low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Ports that the decoded code reaches, and ports with a fault
  for (genvar i = 0; i < PORTS; i++) begin : g_hit
    assign hit[i] = port_priority[3*i+:3] >= shutdown_code;
  end
  assign fault = oc_timeout | fast_overload | manual_shutdown | {PORTS{!supply_ok}};
  // Run length of the reset pin held low; saturates so a long hold cannot wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) low_cnt <= 8'h00;
    else if (reset_in_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  end
  //////////////////////////////////////////////////////////////
  sequence s_code_done;
    shutdown_event ##1 !shutdown_event;
  endsequence
  a_int_follows: assert property ($past(arst_n) |-> int_oe == $past(|int_flags) && !int_out)
    else $error("interrupt pin does not follow the flags");
  a_sda_follows: assert property ($past(arst_n) |-> serial_data_out_oe == $past(sda_drive_low) && !serial_data_out)
    else $error("data output does not follow the engine");
  a_addr_copy: assert property ($past(arst_n) |-> bus_address == $past(bus_address_pins))
    else $error("bus address does not follow its pins");
  a_gate_fault_kill: assert property (|fault |-> ##2 (port_gate_drive & $past(fault, 2)) == '0)
    else $error("gate left on after a fault");
  a_sense_res_mode: assert property (sense_res_en == ~(probe_low_en | probe_high_en | port_gate_drive))
    else $error("sense resistor in the wrong mode");
  a_probe_order: assert property ((probe_high_en & ~$past(probe_high_en) & ~$past(probe_low_en)) == '0 && (probe_low_en & probe_high_en) == '0)
    else $error("probe phases out of order");
  a_event_pulse: assert property (shutdown_event |-> s_code_done)
    else $error("code event longer than one cycle");
  a_code_kill: assert property (shutdown_event |-> (port_gate_drive & hit) == '0)
    else $error("port above the code left on");
  a_pin_reset: assert property (int'(low_cnt) > DEGLITCH_CYC |-> port_gate_drive == '0)
    else $error("reset pin did not turn ports off");
endmodule
bind pse_port_shutdown_control pse_port_shutdown_control_props #(.PORTS(PORTS), .DEGLITCH_CYC(DEGLITCH_CYC)) u_props (.*);

/* File: dv/pd_port_model.sv */
// Model of the powered devices on the eight ports: charge, signature, class.
// Assumes the block's drive outputs as inputs; charge and class answers come from registers, the signature is not registered.
module pd_port_model #(
  // Port 2 starts charged; ports 1 and 3 answer class late
  parameter logic [7:0] CHARGED = 8'h04,
  parameter logic [7:0] SLOW = 8'h0a
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Drive from the block
  input wire logic [7:0] discharge_en,
  input wire logic [7:0] probe_high_en,
  input wire logic [7:0] class_en,
  // Answers to the block
  output logic [7:0] port_volt_high,
  output logic [7:0] detect_valid,
  output logic [7:0] class_done
);
  logic [7:0] c1;
  logic [7:0] c2;
  // Charge bleeds away only while the discharge resistor is on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_volt_high <= CHARGED;
      c1 <= 8'h00;
      c2 <= 8'h00;
    end else begin
      port_volt_high <= port_volt_high & ~discharge_en;
      c1 <= class_en;
      c2 <= c1 & class_en;
    end
  end
  // Every load has a good signature; slow ports answer class a cycle later
  assign detect_valid = probe_high_en;
  assign class_done = ((c1 & ~SLOW) | (c2 & SLOW)) & class_en;
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the port shutdown and control block.
// Assumes the checker is bound in and the device model sits on the port side.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reset_in_n = 1'b1;
  logic fast_shutdown_in = 1'b0;
  logic sda_drive_low = 1'b0;
  logic serial_data_in = 1'b1;
  logic supply_ok = 1'b1;
  logic [3:0] bus_address_pins = 4'hf;
  logic [7:0] int_flags = 8'h00, port_enable = 8'h00, oc_timeout = 8'h00;
  logic [7:0] fast_overload = 8'h00, manual_shutdown = 8'h00;
  logic [23:0] port_priority = 24'hfac688; // Port i has priority i
  logic [7:0] port_volt_high, detect_valid, class_done, port_gate_drive, discharge_en;
  logic [7:0] probe_low_en, probe_high_en, class_en, sense_res_en, ev_gate;
  logic int_out, int_oe, serial_data_out, serial_data_out_oe, serial_data_rx, shutdown_event;
  logic [3:0] bus_address;
  logic [2:0] shutdown_code, ev_code;
  int n_mismatch = 0;
  int samples_checked = 0;
  int ev_n = 0;
  // Short counts keep the run brief; expectations below use these values
  pse_port_shutdown_control #(.DEGLITCH_CYC(3), .BACKOFF_CYC(50), .PROBE_CYC(4), .SD_LONG_CYC(5),
    .SD_GAP_CYC(20)) dut (.*);
  pd_port_model pd (.*);
  //////////////////////////////////////////////////////////////
  // Records each code event, since it stands for one cycle only
  always @(negedge clk) begin
    if (shutdown_event === 1'b1) begin
      ev_n++;
      ev_gate = port_gate_drive;
      ev_code = shutdown_code;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_on(input logic [7:0] m);
    int n;
    n = 0;
    while (port_gate_drive !== m && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(port_gate_drive, m, "ports did not come on");
  endtask
  task automatic pulse(input int hi_cyc);
    @(posedge clk);
    fast_shutdown_in <= 1'b1;
    cyc(hi_cyc);
    fast_shutdown_in <= 1'b0;
    cyc(6);
  endtask
  task automatic t_pins();
    @(posedge clk);
    int_flags <= 8'h40;
    sda_drive_low <= 1'b1;
    bus_address_pins <= 4'h5;
    cyc(2);
    @(negedge clk);
    chk(int_oe, 1, "interrupt not pulled");
    chk({serial_data_out_oe, serial_data_out}, 2'b10, "data not pulled");
    chk(bus_address, 4'h5, "address");
    @(posedge clk);
    int_flags <= 8'h00;
    sda_drive_low <= 1'b0;
    serial_data_in <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk({int_oe, serial_data_out_oe, serial_data_rx}, 3'b000, "pins not released");
    $display("done pins");
  endtask
  task automatic t_detect();
    int lo, hi, dis;
    lo = 0;
    hi = 0;
    dis = 0;
    @(posedge clk);
    port_enable <= 8'h05;
    repeat (120) begin
      @(negedge clk);
      lo += probe_low_en[0];
      hi += probe_high_en[0];
      dis += discharge_en[2];
    end
    chk(lo, 4, "low probe length");
    chk(hi, 4, "high probe length");
    chk(dis, 50, "backoff length");
    chk(sense_res_en, 8'hfa, "sense resistor while on");
    $display("done detect");
  endtask
  task automatic t_class_all();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    port_enable <= 8'hff;
    repeat (30) begin
      @(negedge clk);
      seen |= (class_en === 8'hfa);
    end
    chk(seen, 1, "ports not classified together");
    wait_on(8'hff);
    $display("done class");
  endtask
  task automatic t_faults();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      case (k)
        0: oc_timeout <= 8'h08;
        1: manual_shutdown <= 8'h08;
        2: fast_overload <= 8'h08;
        default: supply_ok <= 1'b0;
      endcase
      cyc(2);
      @(negedge clk);
      chk(port_gate_drive, k == 3 ? 8'h00 : 8'hf7, "gate not forced low");
      @(posedge clk);
      {oc_timeout, manual_shutdown, fast_overload, supply_ok} <= {24'h000000, 1'b1};
      wait_on(8'hff);
    end
    $display("done faults");
  endtask
  task automatic t_shutdown();
    ev_n = 0;
    pulse(2);
    cyc(30);
    chk(ev_n, 0, "glitch decoded");
    pulse(8);
    pulse(8);
    pulse(4);
    cyc(10);
    chk(ev_n, 1, "code event count");
    chk(ev_code, 3'h6, "code value");
    chk(ev_gate, 8'h3f, "priority shutdown");
    wait_on(8'hff);
    $display("done shutdown");
  endtask
  task automatic t_reset_pin();
    @(posedge clk);
    reset_in_n <= 1'b0;
    cyc(2);
    reset_in_n <= 1'b1;
    cyc(5);
    @(negedge clk);
    chk(port_gate_drive, 8'hff, "short reset acted");
    @(posedge clk);
    reset_in_n <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk(port_gate_drive | class_en | probe_low_en | discharge_en, 8'h00, "ports left on");
    @(posedge clk);
    reset_in_n <= 1'b1;
    wait_on(8'hff);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk({port_gate_drive, sense_res_en, bus_address}, 20'h00fff, "power-on reset");
    cyc(3);
    arst_n <= 1'b1;
    wait_on(8'hff);
    $display("done resets");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    cyc(3);
    arst_n <= 1'b1;
    t_pins();
    t_detect();
    t_class_all();
    t_faults();
    t_shutdown();
    t_reset_pin();
    conclude();
  end
  // The whole run needs about 400 cycles; this cuts a hang well beyond that
  initial begin
    #100us;
    n_mismatch++;
    conclude();
  end
endmodule
